// ==== rtl/spimc_pkg.sv ====
package spimc_pkg;
   localparam int FRAME_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
   localparam int CNT_W = 16;
   localparam int NUM_IRQ = 6;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WMARK = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_RAW = 8'h18;
   localparam logic [7:0] OFS_MIS = 8'h1C;
   localparam logic [7:0] OFS_CLR = 8'h20;
   localparam logic [7:0] OFS_RXCNT = 8'h28;
   localparam logic [7:0] OFS_DUMMY = 8'h2C;
   localparam logic [7:0] OFS_TXCNT = 8'h30;
   // field positions
   localparam int CTRL_EN_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int WM_TX_LSB = 8;
   localparam int STAT_RXLVL_LSB = 8;
   localparam int STAT_BUSY_BIT = 16;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_TO = 2;
   localparam int IRQ_OV = 3;
   localparam int IRQ_UN = 4;
   localparam int IRQ_TXE = 5;
   // reset values
   localparam logic [LVL_W-1:0] RST_RX_WM = 4'h4;
   localparam logic [LVL_W-1:0] RST_TX_WM = 4'h4;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_PERIOD_NS = 200;
   localparam int SCLK_HALF = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int TIMEOUT_BITS = 32;
   localparam int TIMEOUT_CYC = TIMEOUT_BITS * SCLK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
   localparam int DIV_W = $clog2(SCLK_HALF + 1);
   localparam int BIT_W = $clog2(FRAME_W);
   typedef enum logic [1:0] {
      MODE_FULL = 2'h0, MODE_TXONLY = 2'h1, MODE_RXONLY = 2'h2, MODE_COMB = 2'h3
   } spimc_mode_e;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_LOAD = 4'h2, ST_SHIFT = 4'h4, ST_DONE = 4'h8
   } spimc_state_e;
endpackage

// ==== rtl/spimc_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module spimc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8,
   parameter int LW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic push,
   input wire logic [W-1:0] wdata,
   input wire logic pop,
   output logic [W-1:0] rdata,
   output logic [LW-1:0] level,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
   logic [LW-1:0] count_ff, nxt_count;
   logic [W-1:0] rdata_ff, nxt_rdata;
   logic doPush, doPop;

   // depth is a power of two so pointers wrap by themselves
   always_comb begin
      doPush = push && (count_ff != LW'(DEPTH));
      doPop = pop && (count_ff != '0);
      nxt_wrPtr = doPush ? wrPtr_ff + 1'b1 : wrPtr_ff;
      nxt_rdPtr = doPop ? rdPtr_ff + 1'b1 : rdPtr_ff;
      nxt_count = count_ff;
      if (doPush && !doPop) begin
         nxt_count = count_ff + 1'b1;
      end else if (doPop && !doPush) begin
         nxt_count = count_ff - 1'b1;
      end
      // head word lags a pointer move by one cycle
      nxt_rdata = mem[rdPtr_ff];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         rdata_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr_ff] <= wdata;
      end
   end

   assign rdata = rdata_ff;
   assign level = count_ff;
   assign full = (count_ff == LW'(DEPTH));
   assign empty = (count_ff == '0);
endmodule
`default_nettype wire

// ==== rtl/spimc_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module spimc_master
   import spimc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic sclk,
   output logic mosi,
   output logic csN,
   input wire logic miso
);
   // register file
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic portEnable_ff, nxt_portEnable;
   spimc_mode_e mode_ff, nxt_mode;
   logic [LVL_W-1:0] rxWm_ff, nxt_rxWm, txWm_ff, nxt_txWm;
   logic [NUM_IRQ-1:0] mask_ff, nxt_mask, raw_ff, nxt_raw;
   logic [FRAME_W-1:0] dummy_ff, nxt_dummy;
   logic irq_ff, nxt_irq;
   logic apbDone, apbWr, apbRd, mapped, wrRxCnt, wrTxCnt, txPush, rxPop;
   logic [NUM_IRQ-1:0] clrPulse;
   // engine
   spimc_state_e state_ff, nxt_state;
   spimc_mode_e frameMode_ff, nxt_frameMode;
   logic [CNT_W-1:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
   logic lockRx_ff, nxt_lockRx, lockTx_ff, nxt_lockTx;
   logic useFifo_ff, nxt_useFifo, cap_ff, nxt_cap;
   logic [FRAME_W-1:0] shift_ff, nxt_shift, rxShift_ff, nxt_rxShift;
   logic [DIV_W-1:0] div_ff, nxt_div;
   logic [BIT_W-1:0] bit_ff, nxt_bit;
   logic sclk_ff, nxt_sclk, mosi_ff, nxt_mosi, csN_ff, nxt_csN;
   logic misoMeta_ff, misoSync_ff;
   logic go, selFifo, selCap, decRx, decTx, underrunEv, overrunEv, popTx, pushRx;
   // timeout
   logic [TO_W-1:0] to_ff, nxt_to;
   logic timeoutEv;
   // queues
   logic [FRAME_W-1:0] txHead, rxHead;
   logic [LVL_W-1:0] txLevel, rxLevel;
   logic txFull, txEmpty, rxFull, rxEmpty;

   spimc_fifo #(.W(FRAME_W), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) txQueue (
      .clk(clk), .reset_n(reset_n), .push(txPush), .wdata(pwdata[FRAME_W-1:0]),
      .pop(popTx), .rdata(txHead), .level(txLevel), .full(txFull), .empty(txEmpty));
   // overrun leaves queue intact: push is suppressed when full
   spimc_fifo #(.W(FRAME_W), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) rxQueue (
      .clk(clk), .reset_n(reset_n), .push(pushRx), .wdata(rxShift_ff),
      .pop(rxPop), .rdata(rxHead), .level(rxLevel), .full(rxFull), .empty(rxEmpty));

   // apb slave: one wait state, data registered on the same edge as pready
   always_comb begin
      apbDone = psel && penable && pready_ff;
      apbWr = apbDone && pwrite;
      apbRd = apbDone && !pwrite;
      mapped = 1'b1;
      nxt_prdata = prdata_ff;
      case (paddr)
         OFS_CTRL: nxt_prdata = 32'({mode_ff, portEnable_ff, 1'b0});
         OFS_WMARK: nxt_prdata = 32'({txWm_ff, 4'h0, rxWm_ff});
         OFS_DATA: nxt_prdata = 32'(rxHead);
         OFS_STAT: nxt_prdata = 32'({state_ff != ST_IDLE, 4'h0, rxLevel, 4'h0, txLevel});
         OFS_MASK: nxt_prdata = 32'(mask_ff);
         OFS_RAW: nxt_prdata = 32'(raw_ff);
         OFS_MIS: nxt_prdata = 32'(raw_ff & mask_ff);
         OFS_CLR: nxt_prdata = 32'h0;
         OFS_RXCNT: nxt_prdata = 32'(rxCnt_ff);
         OFS_DUMMY: nxt_prdata = 32'(dummy_ff);
         OFS_TXCNT: nxt_prdata = 32'(txCnt_ff);
         default: mapped = 1'b0;
      endcase
      nxt_pready = psel && penable && !pready_ff;
      nxt_pslverr = nxt_pready && !mapped;
      if (!nxt_pready) begin
         nxt_prdata = 32'h0;
      end
      wrRxCnt = apbWr && (paddr == OFS_RXCNT);
      wrTxCnt = apbWr && (paddr == OFS_TXCNT);
      txPush = apbWr && (paddr == OFS_DATA);
      rxPop = apbRd && (paddr == OFS_DATA);
      clrPulse = (apbWr && (paddr == OFS_CLR)) ? pwdata[NUM_IRQ-1:0] : '0;
      nxt_portEnable = portEnable_ff;
      nxt_mode = mode_ff;
      nxt_rxWm = rxWm_ff;
      nxt_txWm = txWm_ff;
      nxt_mask = mask_ff;
      nxt_dummy = dummy_ff;
      if (apbWr && paddr == OFS_CTRL) begin
         nxt_portEnable = pwdata[CTRL_EN_BIT];
         nxt_mode = spimc_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
      end
      if (apbWr && paddr == OFS_WMARK) begin
         nxt_rxWm = pwdata[LVL_W-1:0];
         nxt_txWm = pwdata[WM_TX_LSB +: LVL_W];
      end
      if (apbWr && paddr == OFS_MASK) begin
         nxt_mask = pwdata[NUM_IRQ-1:0];
      end
      if (apbWr && paddr == OFS_DUMMY) begin
         nxt_dummy = pwdata[FRAME_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         portEnable_ff <= 1'b0;
         mode_ff <= MODE_FULL;
         rxWm_ff <= RST_RX_WM;
         txWm_ff <= RST_TX_WM;
         mask_ff <= '0;
         dummy_ff <= '0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         portEnable_ff <= nxt_portEnable;
         mode_ff <= nxt_mode;
         rxWm_ff <= nxt_rxWm;
         txWm_ff <= nxt_txWm;
         mask_ff <= nxt_mask;
         dummy_ff <= nxt_dummy;
      end
   end

   // word selection, decided only between words
   always_comb begin
      go = 1'b0;
      selFifo = 1'b0;
      selCap = 1'b1;
      decRx = 1'b0;
      decTx = 1'b0;
      underrunEv = 1'b0;
      unique case (mode_ff)
         MODE_FULL: go = !txEmpty;
         MODE_TXONLY: begin
            go = !txEmpty;
            selCap = 1'b0;
         end
         MODE_RXONLY: begin
            if (!lockRx_ff && !txEmpty && rxCnt_ff != '0) begin
               go = 1'b1;
            end else if (rxCnt_ff != '0) begin
               go = 1'b1;
               decRx = 1'b1;
            end
         end
         MODE_COMB: begin
            if (txCnt_ff != '0 && !lockRx_ff) begin
               go = !txEmpty;
               decTx = !txEmpty;
               underrunEv = txEmpty;
            end else if (rxCnt_ff != '0 && !lockTx_ff && txEmpty) begin
               go = 1'b1;
               decRx = 1'b1;
            end
         end
      endcase
      selFifo = go && !decRx;
      if (state_ff != ST_IDLE || !portEnable_ff) begin
         go = 1'b0;
         decRx = 1'b0;
         decTx = 1'b0;
         underrunEv = 1'b0;
      end
   end

   // serial engine, link clock made by dividing clk
   always_comb begin
      nxt_state = state_ff;
      nxt_frameMode = frameMode_ff;
      nxt_rxCnt = rxCnt_ff;
      nxt_txCnt = txCnt_ff;
      nxt_lockRx = lockRx_ff;
      nxt_lockTx = lockTx_ff;
      nxt_useFifo = useFifo_ff;
      nxt_cap = cap_ff;
      nxt_shift = shift_ff;
      nxt_rxShift = rxShift_ff;
      nxt_div = div_ff;
      nxt_bit = bit_ff;
      nxt_sclk = sclk_ff;
      nxt_mosi = mosi_ff;
      nxt_csN = csN_ff;
      popTx = 1'b0;
      pushRx = 1'b0;
      overrunEv = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            // a counter that reached zero frees the other one
            if (rxCnt_ff == '0) begin
               nxt_lockRx = 1'b0;
            end
            if (txCnt_ff == '0) begin
               nxt_lockTx = 1'b0;
            end
            if (go) begin
               nxt_state = ST_LOAD;
               nxt_frameMode = mode_ff;
               nxt_useFifo = selFifo;
               nxt_cap = selCap;
            end
            if (decRx) begin
               nxt_rxCnt = rxCnt_ff - 1'b1;
               nxt_lockRx = 1'b1;
            end
            if (decTx) begin
               nxt_txCnt = txCnt_ff - 1'b1;
               nxt_lockTx = 1'b1;
            end
         end
         ST_LOAD: begin
            nxt_shift = useFifo_ff ? txHead : dummy_ff;
            nxt_mosi = nxt_shift[FRAME_W-1];
            popTx = useFifo_ff;
            nxt_csN = 1'b0;
            nxt_div = '0;
            nxt_bit = '0;
            nxt_sclk = 1'b0;
            nxt_state = ST_SHIFT;
         end
         ST_SHIFT: begin
            nxt_div = div_ff + 1'b1;
            if (div_ff == DIV_W'(SCLK_HALF - 1)) begin
               nxt_div = '0;
               nxt_sclk = !sclk_ff;
               if (!sclk_ff) begin
                  nxt_rxShift = {rxShift_ff[FRAME_W-2:0], misoSync_ff};
               end else if (bit_ff == BIT_W'(FRAME_W - 1)) begin
                  nxt_state = ST_DONE;
               end else begin
                  nxt_shift = {shift_ff[FRAME_W-2:0], 1'b0};
                  nxt_mosi = shift_ff[FRAME_W-2];
                  nxt_bit = bit_ff + 1'b1;
               end
            end
         end
         ST_DONE: begin
            nxt_csN = 1'b1;
            pushRx = cap_ff && !rxFull;
            overrunEv = cap_ff && rxFull;
            nxt_state = ST_IDLE;
         end
      endcase
      // software write wins over a decrement in the same cycle
      if (wrRxCnt) begin
         nxt_rxCnt = pwdata[CNT_W-1:0];
      end
      if (wrTxCnt) begin
         nxt_txCnt = pwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         frameMode_ff <= MODE_FULL;
         rxCnt_ff <= '0;
         txCnt_ff <= '0;
         lockRx_ff <= 1'b0;
         lockTx_ff <= 1'b0;
         useFifo_ff <= 1'b0;
         cap_ff <= 1'b0;
         shift_ff <= '0;
         rxShift_ff <= '0;
         div_ff <= '0;
         bit_ff <= '0;
         sclk_ff <= 1'b0;
         mosi_ff <= 1'b0;
         csN_ff <= 1'b1;
         misoMeta_ff <= 1'b0;
         misoSync_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         frameMode_ff <= nxt_frameMode;
         rxCnt_ff <= nxt_rxCnt;
         txCnt_ff <= nxt_txCnt;
         lockRx_ff <= nxt_lockRx;
         lockTx_ff <= nxt_lockTx;
         useFifo_ff <= nxt_useFifo;
         cap_ff <= nxt_cap;
         shift_ff <= nxt_shift;
         rxShift_ff <= nxt_rxShift;
         div_ff <= nxt_div;
         bit_ff <= nxt_bit;
         sclk_ff <= nxt_sclk;
         mosi_ff <= nxt_mosi;
         csN_ff <= nxt_csN;
         misoMeta_ff <= miso;
         misoSync_ff <= misoMeta_ff;
      end
   end

   // interrupt status
   always_comb begin
      nxt_to = to_ff;
      timeoutEv = 1'b0;
      if (rxEmpty || pushRx) begin
         nxt_to = '0;
      end else if (to_ff != TO_W'(TIMEOUT_CYC)) begin
         nxt_to = to_ff + 1'b1;
         timeoutEv = (to_ff == TO_W'(TIMEOUT_CYC - 1));
      end
      nxt_raw = raw_ff & ~clrPulse;
      // level sources follow occupancy, independent of the port enable
      nxt_raw[IRQ_RX] = (rxLevel >= rxWm_ff);
      nxt_raw[IRQ_TX] = (txLevel <= txWm_ff);
      nxt_raw[IRQ_TXE] = txEmpty;
      if (rxEmpty || pushRx) begin
         nxt_raw[IRQ_TO] = 1'b0;
      end
      // events win over a clear in the same cycle
      if (timeoutEv) begin
         nxt_raw[IRQ_TO] = 1'b1;
      end
      if (overrunEv) begin
         nxt_raw[IRQ_OV] = 1'b1;
      end
      if (underrunEv) begin
         nxt_raw[IRQ_UN] = 1'b1;
      end
      nxt_irq = |(raw_ff & mask_ff);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         to_ff <= '0;
         raw_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         to_ff <= nxt_to;
         raw_ff <= nxt_raw;
         irq_ff <= nxt_irq;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign sclk = sclk_ff;
   assign mosi = mosi_ff;
   assign csN = csN_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   irq_or_a: assert property ((|(raw_ff & mask_ff)) |=> irq_ff)
      else $error("irq not raised for masked source");
   irq_masked_a: assert property ((raw_ff & mask_ff) == '0 |=> !irq_ff)
      else $error("irq raised with all sources masked");
   mis_read_a: assert property (apbDone && !pwrite && paddr == OFS_MIS
      |-> prdata_ff[NUM_IRQ-1:0] == $past(raw_ff & mask_ff))
      else $error("masked status read wrong");
   rx_wmark_a: assert property ((rxLevel < rxWm_ff) |=> !raw_ff[IRQ_RX])
      else $error("receive flag set below watermark");
   tx_wmark_a: assert property ((txLevel <= txWm_ff) |=> raw_ff[IRQ_TX])
      else $error("transmit flag missing at watermark");
   timeout_set_a: assert property (timeoutEv && !rxPop |=> raw_ff[IRQ_TO] && !rxEmpty)
      else $error("timeout flag not set");
   timeout_clr_a: assert property (rxEmpty && !timeoutEv |=> !raw_ff[IRQ_TO])
      else $error("timeout flag stays with empty queue");
   overrun_keep_a: assert property (overrunEv && !rxPop |=> raw_ff[IRQ_OV] && rxFull)
      else $error("overrun not flagged or queue altered");
   underrun_hold_a: assert property (raw_ff[IRQ_UN] && !clrPulse[IRQ_UN]
      |=> raw_ff[IRQ_UN])
      else $error("underrun flag dropped without clear");
   txonly_nopush_a: assert property (state_ff == ST_DONE && frameMode_ff == MODE_TXONLY
      |-> !pushRx)
      else $error("transmit only stored received data");
   rx_dec_a: assert property (decRx && !wrRxCnt
      |=> rxCnt_ff == $past(rxCnt_ff) - 1'b1 && state_ff == ST_LOAD && !useFifo_ff)
      else $error("receive count not decremented before dummy word");
   dummy_only_a: assert property (state_ff == ST_LOAD && frameMode_ff == MODE_RXONLY
      && lockRx_ff |-> !useFifo_ff)
      else $error("queue word sent during dummy phase");
   rx_stop_a: assert property (state_ff == ST_IDLE && mode_ff == MODE_RXONLY
      && rxCnt_ff == '0 |=> state_ff == ST_IDLE)
      else $error("receive only ran with zero count");
   mode_hold_a: assert property (state_ff == ST_SHIFT |=> $stable(frameMode_ff))
      else $error("mode changed within a word");

   dummy_frame_c: cover property (state_ff == ST_LOAD && !useFifo_ff);
   comb_switch_c: cover property (lockTx_ff ##[1:1000] lockRx_ff);
   overrun_c: cover property (overrunEv);
   timeout_c: cover property (timeoutEv);
endmodule
`default_nettype wire

// ==== testbench/spimc_slave_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spimc_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic csN,
   output var logic miso,
   output var int frames,
   output var logic [7:0] hist [0:31]
);
   logic [7:0] shOut;
   logic [7:0] shIn;
   initial begin
      frames = 0;
      miso = 1'b0;
   end
   // mode 0: drive after falling edge, capture on rising edge
   always @(negedge csN) begin
      shOut = 8'hC0 + 8'(frames);
      miso = shOut[7];
   end
   always @(posedge sclk) begin
      shIn = {shIn[6:0], mosi};
   end
   always @(negedge sclk) begin
      if (!csN) begin
         shOut = {shOut[6:0], 1'b0};
         miso = shOut[7];
      end
   end
   // released line shows the inverse, never a held copy
   always @(posedge csN) begin
      hist[frames[4:0]] = shIn;
      frames = frames + 1;
      miso = ~miso;
   end
endmodule
`default_nettype wire

// ==== testbench/spi_master_irq_and_transfer_modes_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_master_irq_and_transfer_modes_test import spimc_pkg::*;;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic sclk;
   logic mosi;
   logic csN;
   logic miso;
   int frames;
   logic [7:0] hist [0:31];
   int errors = 0;
   int num_checks = 0;
   int base;
   logic [31:0] rdv;
   logic errv;
   logic [73:0] rows [7];
   always #12.5 clk = ~clk;
   spimc_master DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .sclk(sclk), .mosi(mosi), .csN(csN), .miso(miso));
   spimc_slave_model slave (.sclk(sclk), .mosi(mosi), .csN(csN), .miso(miso),
      .frames(frames), .hist(hist));
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errors++;
         $display("MISMATCH pready expected 1 seen %b", pready);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string w, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(w, e, rdv & m);
   endtask
   // bounded wait on the slave's own frame count
   task automatic waitf(input int n);
      int t;
      t = frames + n;
      for (int k = 0; k < 5000 && frames < t; k++) @(posedge clk);
      if (frames < t) begin
         errors++;
         $display("MISMATCH frames expected %0d seen %0d", t, frames);
      end
      repeat (8) @(posedge clk);
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      report_and_stop();
   end
   initial begin
      rows = '{{1'h1, 8'h2C, 32'h5A, 32'h0, 1'h0}, {1'h0, 8'h2C, 32'h0, 32'h5A, 1'h0},
               {1'h1, 8'h14, 32'h3F, 32'h0, 1'h0}, {1'h0, 8'h14, 32'h0, 32'h3F, 1'h0},
               {1'h0, 8'h1C, 32'h0, 32'h22, 1'h0}, {1'h0, 8'h18, 32'h0, 32'h22, 1'h0},
               {1'h0, 8'h40, 32'h0, 32'h0, 1'h1}};
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd("raw reset", 8'h18, 32'hFFFFFFFF, 32'h22);
      check("irq reset", 32'h0, {31'h0, irq});
      foreach (rows[i]) begin
         apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
         if (!rows[i][73]) check("row read", rows[i][32:1], rdv);
         check("row err", {31'h0, rows[i][0]}, {31'h0, errv});
      end
      check("irq on", 32'h1, {31'h0, irq});
      wr(8'h14, 32'h0);
      repeat (3) @(posedge clk);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h2);
      base = frames;
      for (int i = 0; i < 8; i++) wr(8'h08, 32'h30 + i);
      waitf(8);
      for (int i = 0; i < 8; i++) check("fd out", 32'h30 + i, {24'h0, hist[base + i]});
      rd("rx level", 8'h0C, 32'hF00, 32'h800);
      rd("rx wmark", 8'h18, 32'h1, 32'h1);
      wr(8'h08, 32'h99);
      waitf(1);
      rd("overrun", 8'h18, 32'h8, 32'h8);
      rd("no timeout", 8'h18, 32'h4, 32'h0);
      rd("rx kept", 8'h0C, 32'hF00, 32'h800);
      repeat (300) @(posedge clk);
      rd("timeout", 8'h18, 32'h4, 32'h4);
      wr(8'h20, 32'hC);
      rd("clr", 8'h18, 32'hC, 32'h0);
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'h08, 32'h0);
         check("fd in", 32'hC0 + base + i, rdv & 32'hFF);
      end
      rd("drained", 8'h18, 32'h5, 32'h0);
      wr(8'h00, 32'h6);
      base = frames;
      wr(8'h08, 32'hAB);
      waitf(1);
      check("tx only", 32'hAB, {24'h0, hist[base]});
      rd("tx only rx", 8'h0C, 32'hF00, 32'h0);
      wr(8'h00, 32'h8);
      wr(8'h08, 32'h11);
      rd("txe clr", 8'h18, 32'h22, 32'h2);
      wr(8'h28, 32'h2);
      base = frames;
      wr(8'h00, 32'hA);
      waitf(3);
      check("rx queued", 32'h11, {24'h0, hist[base]});
      rd("rx cnt", 8'h28, 32'hFFFF, 32'h0);
      wr(8'h28, 32'h2);
      wr(8'h08, 32'h22);
      waitf(2);
      for (int i = 1; i < 5; i++) check("dummy", 32'h5A, {24'h0, hist[base + i]});
      repeat (200) @(posedge clk);
      check("rx stop", base + 5, frames);
      wr(8'h00, 32'hC);
      wr(8'h30, 32'h1);
      wr(8'h28, 32'h1);
      base = frames;
      wr(8'h00, 32'hE);
      waitf(2);
      check("comb tx", 32'h22, {24'h0, hist[base]});
      check("comb dummy", 32'h5A, {24'h0, hist[base + 1]});
      rd("comb txcnt", 8'h30, 32'hFFFF, 32'h0);
      wr(8'h30, 32'h1);
      repeat (4) @(posedge clk);
      rd("underrun", 8'h18, 32'h10, 32'h10);
      wr(8'h30, 32'h0);
      rd("underrun held", 8'h18, 32'h10, 32'h10);
      wr(8'h20, 32'h10);
      rd("underrun clr", 8'h18, 32'h10, 32'h0);
      check("comb stop", base + 2, frames);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      check("csN reset", 32'h1, {31'h0, csN});
      check("pready reset", 32'h0, {31'h0, pready});
      reset_n <= 1'b1;
      rd("raw rereset", 8'h18, 32'hFFFFFFFF, 32'h22);
      rd("stat rereset", 8'h0C, 32'hFFFFFFFF, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
